//--- shared/tsr_pkg.sv
// constants, modes and result kinds for the time stamp result datapath
// assumes samples arrive one at a time from the instrument's binary stream
package tsr_pkg;

   // ------------------------------------------------------------------
   // field widths and positions
   // ------------------------------------------------------------------
   localparam int TIME_W      = 32;
   localparam int EVT_W       = 32;
   localparam int STATUS_W    = 16;
   localparam int STAMP_W     = 48;
   localparam int DIV_W       = 96;
   localparam int INTERP_LSB  = 0;
   localparam int INTERP_W    = 6;
   localparam int BLK_START_BIT = 6;
   localparam int INHIBIT_BIT = 7;
   localparam int CHAN_C_SHIFT = 2;

   // ------------------------------------------------------------------
   // time units; stamps are counted in fine units
   // ------------------------------------------------------------------
   localparam longint COARSE_TIME_PS = 2000;
   localparam longint FINE_TIME_PS   = 100;
   localparam longint COARSE_TICKS   = COARSE_TIME_PS / FINE_TIME_PS;
   localparam logic [63:0] PS_PER_S  = 64'h000000E8D4A51000;
   localparam logic [63:0] FREQ_SCALE = PS_PER_S / 64'(FINE_TIME_PS);

   // ------------------------------------------------------------------
   // measurement modes, result kinds, control states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_CTI       = 3'h0,
      MODE_FREQ      = 3'h1,
      MODE_PERIOD    = 3'h2,
      MODE_TI        = 3'h3,
      MODE_SIGNED_TI = 3'h4
   } meas_mode_e;

   typedef enum logic [2:0] {
      KIND_ARM    = 3'h0,
      KIND_CTI    = 3'h1,
      KIND_FREQ   = 3'h2,
      KIND_PERIOD = 3'h3,
      KIND_TI     = 3'h4
   } result_kind_e;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_WAIT  = 4'h2,
      ST_DIV   = 4'h4,
      ST_CHECK = 4'h8
   } calc_state_e;

   localparam logic [6:0] DIV_STEPS = 7'(DIV_W);

endpackage : tsr_pkg

//--- shared/stamp_if.sv
// carries corrected stamps from the stamp former to the result logic
// assumes one clock domain; valid is a one-cycle pulse per sample
`timescale 1ns/1ps
`default_nettype none
interface stamp_if;
   logic                        valid;
   logic                        first;
   logic                        inhibit;
   logic [tsr_pkg::STAMP_W-1:0] time_stamp;
   logic [tsr_pkg::STAMP_W-1:0] event_stamp;
   modport src (output valid, first, inhibit, time_stamp, event_stamp);
   modport dst (input  valid, first, inhibit, time_stamp, event_stamp);
endinterface : stamp_if
`default_nettype wire

//--- logic/stamp_former.sv
// rollover correction and stamp forming for one raw sample per take
// assumes take_in only when a sample is valid; result one cycle later
`timescale 1ns/1ps
`default_nettype none
module stamp_former (
   input  wire logic                         core_clk_in,
   input  wire logic                         nrst_in,
   input  wire logic                         take_in,
   input  wire logic [tsr_pkg::TIME_W-1:0]   time_count_in,
   input  wire logic [tsr_pkg::STATUS_W-1:0] status_in,
   input  wire logic [tsr_pkg::EVT_W-1:0]    event_count_in,
   input  wire logic                         signed_mode_in,
   input  wire logic                         channel_c_in,
   input  wire logic [tsr_pkg::STAMP_W-1:0]  time_ovf_corr_in,
   input  wire logic [tsr_pkg::STAMP_W-1:0]  event_ovf_corr_in,
   stamp_if.src                              sif
);
   typedef struct packed {
      logic [tsr_pkg::TIME_W-1:0]  prev_t;
      logic [tsr_pkg::EVT_W-1:0]   prev_e;
      logic                        have_t;
      logic                        have_e;
      logic [tsr_pkg::STAMP_W-1:0] tacc;
      logic [tsr_pkg::STAMP_W-1:0] eacc;
      logic                        valid;
      logic                        first;
      logic                        inhibit;
      logic [tsr_pkg::STAMP_W-1:0] ts;
      logic [tsr_pkg::STAMP_W-1:0] es;
   } former_s;

   former_s st_reg;
   former_s st_next;
   logic    is_first;
   logic    t_roll;
   logic    e_roll;
   logic [tsr_pkg::STAMP_W-1:0] t_corr;
   logic [tsr_pkg::STAMP_W-1:0] e_corr;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.valid = 1'b0;
      is_first = status_in[tsr_pkg::BLK_START_BIT];
      t_roll   = !signed_mode_in && st_reg.have_t
                 && (time_count_in < st_reg.prev_t);
      e_roll   = !is_first && !signed_mode_in && st_reg.have_e
                 && (event_count_in < st_reg.prev_e);
      t_corr   = st_reg.tacc + (t_roll ? time_ovf_corr_in : '0);
      e_corr   = st_reg.eacc + (e_roll ? event_ovf_corr_in : '0);
      if (take_in) begin
         st_next.valid   = 1'b1;
         st_next.first   = is_first;
         st_next.inhibit = status_in[tsr_pkg::INHIBIT_BIT];
         st_next.tacc    = t_corr;
         st_next.prev_t  = time_count_in;
         st_next.have_t  = 1'b1;
         st_next.ts = (tsr_pkg::STAMP_W'(time_count_in) + t_corr)
                      * tsr_pkg::STAMP_W'(tsr_pkg::COARSE_TICKS)
                      - tsr_pkg::STAMP_W'(status_in[tsr_pkg::INTERP_LSB
                                                    +: tsr_pkg::INTERP_W]);
         if (!is_first && !signed_mode_in) begin
            st_next.eacc   = e_corr;
            st_next.prev_e = event_count_in;
            st_next.have_e = 1'b1;
            st_next.es = (tsr_pkg::STAMP_W'(event_count_in) + e_corr)
                         << (channel_c_in ? tsr_pkg::CHAN_C_SHIFT : 0);
         end else begin
            st_next.es = '0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sif.valid       = st_reg.valid;
   assign sif.first       = st_reg.first;
   assign sif.inhibit     = st_reg.inhibit;
   assign sif.time_stamp  = st_reg.ts;
   assign sif.event_stamp = st_reg.es;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   a_first_flag: assert property (take_in |=> sif.valid
      && sif.first == $past(status_in[tsr_pkg::BLK_START_BIT]))
      else $error("block start flag not carried");
   a_time_roll: assert property (take_in && t_roll |=> st_reg.tacc
      == $past(st_reg.tacc) + $past(time_ovf_corr_in))
      else $error("time rollover not corrected");
   a_event_roll: assert property (take_in && is_first |=> st_reg.eacc
      == $past(st_reg.eacc) && sif.event_stamp == '0)
      else $error("first sample touched event correction");
   a_chan_scale: assert property (take_in && channel_c_in && !is_first
      && !signed_mode_in |=> sif.event_stamp[1:0] == 2'h0)
      else $error("channel c stamp not scaled by four");
endmodule : stamp_former
`default_nettype wire

//--- logic/timestamp_result_calc.sv
// result calculation from corrected time and event stamps
// assumes a sample source with valid/ready and static configuration inputs
`timescale 1ns/1ps
`default_nettype none
module timestamp_result_calc #(
   parameter int DIV_W = tsr_pkg::DIV_W
) (
   input  wire logic                         core_clk_in,
   input  wire logic                         nrst_in,
   input  wire logic                         sample_valid_in,
   output logic                              sample_ready_out,
   input  wire logic [tsr_pkg::TIME_W-1:0]   time_count_in,
   input  wire logic [tsr_pkg::STATUS_W-1:0] status_in,
   input  wire logic [tsr_pkg::EVT_W-1:0]    event_count_in,
   input  wire logic [2:0]                   mode_in,
   input  wire logic                         expanded_in,
   input  wire logic                         channel_c_in,
   input  wire logic [tsr_pkg::STAMP_W-1:0]  path_offset_in,
   input  wire logic [tsr_pkg::STAMP_W-1:0]  time_ovf_corr_in,
   input  wire logic [tsr_pkg::STAMP_W-1:0]  event_ovf_corr_in,
   output logic                              result_valid_out,
   output logic [2:0]                        result_kind_out,
   output logic [tsr_pkg::STAMP_W-1:0]       result_out,
   output logic                              result_inhibit_out,
   output logic                              expanded_valid_out,
   output logic [tsr_pkg::STAMP_W-1:0]       expanded_out,
   output logic                              div_zero_out
);
   typedef struct packed {
      tsr_pkg::calc_state_e        state;
      logic                        need_arm;
      logic                        have_prev;
      logic                        phase_stop;
      logic [tsr_pkg::STAMP_W-1:0] arm_ts;
      logic [tsr_pkg::STAMP_W-1:0] prev_ts;
      logic [tsr_pkg::STAMP_W-1:0] prev_es;
      logic [tsr_pkg::STAMP_W-1:0] start_ts;
      logic [DIV_W-1:0]            quo;
      logic [DIV_W-1:0]            rem;
      logic [DIV_W-1:0]            den;
      logic [6:0]                  cnt;
      tsr_pkg::result_kind_e       kind;
      logic [tsr_pkg::STAMP_W-1:0] res;
      logic                        res_valid;
      logic                        inhibit;
      logic [tsr_pkg::STAMP_W-1:0] aux;
      logic                        aux_valid;
      logic                        div_zero;
   } calc_s;

   calc_s st_reg;
   calc_s st_next;

   stamp_if sif ();

   tsr_pkg::meas_mode_e         mode;
   logic                        block_mode;
   logic                        take;
   logic [tsr_pkg::STAMP_W-1:0] arm_corr;
   logic [tsr_pkg::STAMP_W-1:0] arm_diff;
   logic [tsr_pkg::STAMP_W-1:0] dt;
   logic [tsr_pkg::STAMP_W-1:0] de;
   logic [tsr_pkg::STAMP_W-1:0] pair_diff;
   logic [DIV_W-1:0]            rem_sh;

   assign mode       = tsr_pkg::meas_mode_e'(mode_in);
   assign block_mode = (mode == tsr_pkg::MODE_CTI) || (mode == tsr_pkg::MODE_FREQ)
                       || (mode == tsr_pkg::MODE_PERIOD);
   // one sample in flight: ready stays low while a stamp is paired or divided
   assign sample_ready_out = (st_reg.state == tsr_pkg::ST_IDLE);
   assign take = sample_valid_in && sample_ready_out;

   // ------------------------------------------------------------------
   // stamp forming
   // ------------------------------------------------------------------
   stamp_former u_stamp_former (
      .core_clk_in       (core_clk_in),
      .nrst_in           (nrst_in),
      .take_in           (take),
      .time_count_in     (time_count_in),
      .status_in         (status_in),
      .event_count_in    (event_count_in),
      .signed_mode_in    (mode == tsr_pkg::MODE_SIGNED_TI),
      .channel_c_in      (channel_c_in),
      .time_ovf_corr_in  (time_ovf_corr_in),
      .event_ovf_corr_in (event_ovf_corr_in),
      .sif               (sif.src)
   );

   // ------------------------------------------------------------------
   // differences
   // ------------------------------------------------------------------
   // differences wrap in two's complement, so a stop ahead of its start reads negative
   assign arm_corr  = sif.time_stamp - path_offset_in;
   assign arm_diff  = sif.time_stamp - st_reg.arm_ts;
   assign dt        = sif.time_stamp - st_reg.prev_ts;
   assign de        = sif.event_stamp - st_reg.prev_es;
   assign pair_diff = sif.time_stamp + path_offset_in - st_reg.start_ts;
   assign rem_sh    = {st_reg.rem[DIV_W-2:0], st_reg.quo[DIV_W-1]};

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      st_next           = st_reg;
      st_next.res_valid = 1'b0;
      st_next.aux_valid = 1'b0;
      case (st_reg.state)
         tsr_pkg::ST_IDLE: begin
            if (take) begin
               st_next.state = tsr_pkg::ST_WAIT;
            end
         end
         tsr_pkg::ST_WAIT: begin
            st_next.state   = tsr_pkg::ST_IDLE;
            st_next.inhibit = sif.inhibit;
            if (block_mode) begin
               // a block-start sample only holds the arming stamp; its result comes next
               if (sif.first) begin
                  st_next.arm_ts    = arm_corr;
                  st_next.need_arm  = 1'b1;
                  st_next.have_prev = 1'b0;
               end else begin
                  st_next.prev_ts   = sif.time_stamp;
                  st_next.prev_es   = sif.event_stamp;
                  st_next.have_prev = 1'b1;
                  if (st_reg.need_arm) begin
                     st_next.need_arm  = 1'b0;
                     st_next.kind      = tsr_pkg::KIND_ARM;
                     st_next.res       = arm_diff;
                     st_next.res_valid = 1'b1;
                  end else if (st_reg.have_prev) begin
                     if (mode == tsr_pkg::MODE_CTI) begin
                        st_next.kind      = tsr_pkg::KIND_CTI;
                        st_next.res       = dt;
                        st_next.res_valid = 1'b1;
                        st_next.aux       = de - tsr_pkg::STAMP_W'(1);
                        st_next.aux_valid = expanded_in;
                     end else begin
                        st_next.aux   = dt;
                        st_next.state = tsr_pkg::ST_DIV;
                        st_next.cnt   = tsr_pkg::DIV_STEPS;
                        st_next.rem   = '0;
                        if (mode == tsr_pkg::MODE_FREQ) begin
                           st_next.kind = tsr_pkg::KIND_FREQ;
                           st_next.quo  = DIV_W'(de) * DIV_W'(tsr_pkg::FREQ_SCALE);
                           st_next.den  = DIV_W'(dt);
                        end else begin
                           st_next.kind = tsr_pkg::KIND_PERIOD;
                           st_next.quo  = DIV_W'(dt);
                           st_next.den  = DIV_W'(de);
                        end
                     end
                  end
               end
            end else begin
               // a block start always opens a new pair as its start
               if (sif.first || !st_reg.phase_stop) begin
                  st_next.start_ts   = sif.time_stamp;
                  st_next.phase_stop = 1'b1;
               end else begin
                  st_next.phase_stop = 1'b0;
                  st_next.kind       = tsr_pkg::KIND_TI;
                  st_next.res        = pair_diff;
                  st_next.res_valid  = 1'b1;
               end
            end
         end
         // restoring division: one quotient bit a cycle, dividend shifted out of quo
         tsr_pkg::ST_DIV: begin
            if (rem_sh >= st_reg.den) begin
               st_next.rem = rem_sh - st_reg.den;
               st_next.quo = {st_reg.quo[DIV_W-2:0], 1'b1};
            end else begin
               st_next.rem = rem_sh;
               st_next.quo = {st_reg.quo[DIV_W-2:0], 1'b0};
            end
            st_next.cnt = st_reg.cnt - 7'h01;
            if (st_reg.cnt == 7'h01) begin
               st_next.state = tsr_pkg::ST_CHECK;
            end
         end
         tsr_pkg::ST_CHECK: begin
            st_next.state     = tsr_pkg::ST_IDLE;
            // a zero divisor leaves the quotient all ones; the flag tells it apart
            st_next.div_zero  = (st_reg.den == '0);
            st_next.res       = st_reg.quo[tsr_pkg::STAMP_W-1:0];
            st_next.res_valid = 1'b1;
            st_next.aux_valid = expanded_in;
         end
         default: begin
            st_next.state = tsr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg       <= '0;
         st_reg.state <= tsr_pkg::ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign result_valid_out   = st_reg.res_valid;
   assign result_kind_out    = st_reg.kind;
   assign result_out         = st_reg.res;
   assign result_inhibit_out = st_reg.inhibit;
   assign expanded_valid_out = st_reg.aux_valid;
   assign expanded_out       = st_reg.aux;
   assign div_zero_out       = st_reg.div_zero;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   a_offset_first: assert property (sif.valid && sif.first && block_mode
      |=> st_reg.arm_ts == $past(arm_corr) && !result_valid_out)
      else $error("first stamp offset wrong");

   a_block_restart: assert property (sif.valid && sif.first && block_mode
      |=> st_reg.need_arm && !st_reg.have_prev)
      else $error("block start did not restart pairing");

   a_arm_data: assert property (sif.valid && !sif.first && block_mode
      && st_reg.need_arm |=> result_valid_out
      && result_kind_out == tsr_pkg::KIND_ARM
      && result_out == $past(arm_diff))
      else $error("block arming data wrong");

   a_cti_value: assert property (sif.valid && !sif.first
      && mode == tsr_pkg::MODE_CTI && !st_reg.need_arm && st_reg.have_prev
      |=> result_valid_out && result_out == $past(dt))
      else $error("continuous interval wrong");

   a_missed_count: assert property (sif.valid && !sif.first && expanded_in
      && mode == tsr_pkg::MODE_CTI && !st_reg.need_arm && st_reg.have_prev
      |=> expanded_valid_out
      && expanded_out == $past(de) - tsr_pkg::STAMP_W'(1))
      else $error("missed events wrong");

   a_div_done: assert property ($rose(st_reg.state == tsr_pkg::ST_DIV)
      |-> ##[97:99] result_valid_out)
      else $error("quotient not delivered in time");

   a_div_zero: assert property (st_reg.state == tsr_pkg::ST_CHECK
      |=> result_valid_out && div_zero_out == $past(st_reg.den == '0))
      else $error("zero divisor flag wrong");

   a_gate_time: assert property ($rose(st_reg.state == tsr_pkg::ST_DIV)
      |-> st_reg.aux == $past(dt))
      else $error("gate time wrong");

   a_pair_diff: assert property (sif.valid && !block_mode && !sif.first
      && st_reg.phase_stop |=> result_valid_out
      && result_kind_out == tsr_pkg::KIND_TI
      && result_out == $past(pair_diff))
      else $error("pair interval wrong");

   a_start_kept: assert property (sif.valid && !block_mode
      && (sif.first || !st_reg.phase_stop)
      |=> st_reg.start_ts == $past(sif.time_stamp) && !result_valid_out)
      else $error("start stamp altered");

   a_ready_busy: assert property (take |=> !sample_ready_out)
      else $error("sample taken while busy");

   // ------------------------------------------------------------------
   // cover points
   // ------------------------------------------------------------------
   c_arm_out: cover property (result_valid_out
      && result_kind_out == tsr_pkg::KIND_ARM);

   c_freq_out: cover property (result_valid_out
      && result_kind_out == tsr_pkg::KIND_FREQ && expanded_valid_out);

   c_neg_ti: cover property (result_valid_out
      && mode == tsr_pkg::MODE_SIGNED_TI
      && result_out[tsr_pkg::STAMP_W-1]);

   c_cti_missed: cover property (expanded_valid_out
      && result_kind_out == tsr_pkg::KIND_CTI);
endmodule : timestamp_result_calc
`default_nettype wire

//--- tb/sample_source.sv
// sample source model: presents one raw sample at a time
// assumes ready is sampled on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sample_source (
   input  wire logic        clk_in,
   input  wire logic        ready_in,
   output logic             valid_out,
   output logic [31:0]      time_out,
   output logic [15:0]      status_out,
   output logic [31:0]      event_out
);
   initial valid_out = 1'b0;
   initial {time_out, status_out, event_out} = '1;

   task automatic send(input logic [31:0] t, input logic [15:0] s, input logic [31:0] e);
      @(negedge clk_in);
      valid_out = 1'b1;
      {time_out, status_out, event_out} = {t, s, e};
      while (ready_in !== 1'b1) @(negedge clk_in);
      @(posedge clk_in);
      @(negedge clk_in);
      valid_out = 1'b0;
      {time_out, status_out, event_out} = ~{t, s, e};
   endtask : send
endmodule : sample_source
`default_nettype wire

//--- tb/timestamp_result_calc_tb_top.sv
// self-checking bench for the time stamp result datapath
// assumes the sample source model and the design package
`timescale 1ns/1ps
`default_nettype none
module timestamp_result_calc_tb_top;
   logic        clk;
   logic        nrst;
   logic        rdy;
   logic        vld;
   logic [31:0] tc;
   logic [15:0] st;
   logic [31:0] ev;
   logic [2:0]  mode;
   logic        xen;
   logic        chc;
   logic        rv;
   logic [2:0]  kind;
   logic [47:0] res;
   logic        inh;
   logic        xv;
   logic [47:0] xres;
   logic        dz;
   int          n_errors = 0;
   int          n_tests = 0;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   sample_source u_sample_source (.clk_in(clk), .ready_in(rdy), .valid_out(vld),
      .time_out(tc), .status_out(st), .event_out(ev));
   timestamp_result_calc u_timestamp_result_calc (.core_clk_in(clk), .nrst_in(nrst),
      .sample_valid_in(vld), .sample_ready_out(rdy), .time_count_in(tc), .status_in(st),
      .event_count_in(ev), .mode_in(mode), .expanded_in(xen), .channel_c_in(chc),
      .path_offset_in(48'h7), .time_ovf_corr_in(48'h100), .event_ovf_corr_in(48'h1000),
      .result_valid_out(rv), .result_kind_out(kind), .result_out(res),
      .result_inhibit_out(inh), .expanded_valid_out(xv), .expanded_out(xres),
      .div_zero_out(dz));

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   task automatic restart(input logic [2:0] m, input logic x, input logic c);
      nrst = 1'b0;
      mode = m;
      xen = x;
      chc = c;
      repeat (6) @(negedge clk);
      chk({46'h0, rdy, rv}, 48'h2);
      nrst = 1'b1;
   endtask : restart

   // waits for a result pulse, then judges kind, value and expanded data
   task automatic get(input logic [2:0] k, input logic [47:0] r, input logic x,
                      input logic [47:0] xr);
      int i;
      i = 0;
      while (rv !== 1'b1 && i < 300) begin
         @(negedge clk);
         i++;
      end
      chk({44'h0, rv, kind}, {44'h0, 1'b1, k});
      chk(res, r);
      chk({47'h0, xv}, {47'h0, x});
      if (x) begin
         chk(xres, xr);
      end
   endtask : get

   task automatic s_cti();
      restart(tsr_pkg::MODE_CTI, 1'b1, 1'b0);
      u_sample_source.send(32'h64, 16'h0040, 32'h0);
      u_sample_source.send(32'h6E, 16'h0003, 32'h32);
      get(tsr_pkg::KIND_ARM, 48'hCC, 1'b0, 48'h0);
      u_sample_source.send(32'h7D, 16'h0000, 32'h3C);
      get(tsr_pkg::KIND_CTI, 48'h12F, 1'b1, 48'h9);
   endtask : s_cti

   task automatic s_roll();
      restart(tsr_pkg::MODE_CTI, 1'b1, 1'b0);
      u_sample_source.send(32'hC8, 16'h0040, 32'h0);
      u_sample_source.send(32'hD2, 16'h0000, 32'h5A);
      get(tsr_pkg::KIND_ARM, 48'hCF, 1'b0, 48'h0);
      u_sample_source.send(32'hA, 16'h0000, 32'h5);
      get(tsr_pkg::KIND_CTI, 48'h460, 1'b1, 48'hFAA);
   endtask : s_roll

   task automatic s_freq(input logic [2:0] m, input logic c, input logic [31:0] e,
                         input logic [2:0] k, input logic [47:0] r, input logic z);
      restart(m, 1'b1, c);
      u_sample_source.send(32'h3E8, 16'h0040, 32'h0);
      u_sample_source.send(32'h3E8, 16'h0000, 32'hC8);
      get(tsr_pkg::KIND_ARM, 48'h7, 1'b0, 48'h0);
      u_sample_source.send(32'h7D0, 16'h0000, e);
      get(k, r, 1'b1, 48'h4E20);
      chk({47'h0, dz}, {47'h0, z});
   endtask : s_freq

   task automatic s_ti(input logic sgn);
      restart(sgn ? tsr_pkg::MODE_SIGNED_TI : tsr_pkg::MODE_TI, 1'b0, 1'b0);
      u_sample_source.send(sgn ? 32'h12C : 32'h64, 16'h0040, 32'h5A5A5A5A);
      u_sample_source.send(sgn ? 32'hFA : 32'h96, sgn ? 16'h0005 : 16'h0080, 32'hA5A5A5A5);
      get(tsr_pkg::KIND_TI, sgn ? -48'h3E6 : 48'h3EF, 1'b0, 48'h0);
      chk({47'h0, inh}, {47'h0, ~sgn});
   endtask : s_ti

   initial begin
      s_cti();
      s_roll();
      s_freq(tsr_pkg::MODE_FREQ, 1'b1, 32'h12C, tsr_pkg::KIND_FREQ, 48'hBEBC200, 1'b0);
      s_freq(tsr_pkg::MODE_PERIOD, 1'b0, 32'h12C, tsr_pkg::KIND_PERIOD, 48'hC8, 1'b0);
      s_freq(tsr_pkg::MODE_PERIOD, 1'b0, 32'hC8, tsr_pkg::KIND_PERIOD, ~48'h0, 1'b1);
      s_ti(1'b0);
      s_ti(1'b1);
      wrap_up();
   end

   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule : timestamp_result_calc_tb_top
`default_nettype wire
